/* logic/sdc_config.v */
/*
 * Diagnostic controls and socket DMA setup registers of one socket
 * function of a card bridge, with the small pieces of logic they steer:
 * identity masking, card-change interrupt routing, retry latency,
 * discard timers, request pin choice and the DMA window decode.
 * Assumes a plain synchronous register port with one-cycle strobes and
 * inputs synchronous to clk; all state freezes while clkEn is low.
 */
`timescale 1ns/1ns
`include "sdc_defines.vh"

////////////////////////////////////////////////////////////////////////
// discard timer: counts while a completion waits, pulses at its limit
module sdc_discard_timer
#(
    parameter SHORT_LIMIT = `SDC_DISCARD_SHORT,
    parameter LONG_LIMIT = `SDC_DISCARD_LONG,
    parameter CW = 16
)
(
    input wire clk,
    input wire nrst,
    input wire clkEn,
    input wire run,
    input wire selShort,
    output reg expired_q
);
    reg [CW-1:0] count_q;
    wire [CW-1:0] lastCount;

    assign lastCount = selShort ? SHORT_LIMIT[CW-1:0] - 1'b1 : LONG_LIMIT[CW-1:0] - 1'b1;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_q <= {CW{1'b0}};
            expired_q <= 1'b0;
        end
        else if (clkEn)
        begin
            expired_q <= 1'b0;
            if (!run)
            begin
                count_q <= {CW{1'b0}};
            end
            // >= so a select change mid-count still ends the wait
            else if (count_q >= lastCount)
            begin
                count_q <= {CW{1'b0}};
                expired_q <= 1'b1;
            end
            else
            begin
                count_q <= count_q + 1'b1;
            end
        end
    end
endmodule // sdc_discard_timer

////////////////////////////////////////////////////////////////////////
// Summary of operation
// (R01) identity mask 0 reads true ids; 1 reads all ones.
// (R02) route select 0: card-change irq to host when compat 803 bit 4 set.
// (R03) route select 1: irq to host when compat 805 bits 7:4 zero.
// (R04) retry-disable bit turns delayed transactions off.
// (R05) retry-extend bit raises retry latency limit from 16 to 64.
// (R06) card-side discard timer: 2^10 when selected, else 2^15.
// (R07) host-side discard timer: 2^10 when selected, else 2^15.
// (R08) change_irq_enable_a enable 1 makes card-change irq asynchronous; 0 does not.
// (R09) host reaches global diagnostic bits only through function 0.
// (R10) diagnostic bit 6 is stored, readable, and has no effect.
// (R11) request pin field: none, speaker, IOIS16 or INPACK pin.
// (R12) request select bits 31 to 2 read zero.
// (R13) DMA block is 16 bytes in the lowest 64 Kbytes of I/O.
// (R14) no 32-bit DMA; widest card transfer is 16 bits.
// (R15) window bits 15 to 4 hold the 16-byte aligned I/O base.
// (R16) width field: 00 eight bits, 01 sixteen bits, others reserved.
// (R17) decode enable bit 0 enables the block; resets disabled.
// (R18) extended addressing bit 3 always reads zero.
module sdc_config
#(
    // arbitrary identity values, not those of any real part
    parameter [15:0] VENDOR_ID = 16'h1234,
    parameter [15:0] DEVICE_ID = 16'h5678,
    parameter DISCARD_SHORT = `SDC_DISCARD_SHORT,
    parameter DISCARD_LONG = `SDC_DISCARD_LONG
)
(
    input wire clk,
    input wire nrst,
    input wire clkEn,
    input wire [7:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata_q,
    input wire changePending,
    input wire compat803Bit4,
    input wire [3:0] compat805Irq,
    output reg changeIrqHost_q,
    output reg changeIrqAsync_q,
    output reg delayedTxnOff_q,
    input wire retryWait,
    output reg retryTimeout_q,
    input wire cardDiscardRun,
    input wire hostDiscardRun,
    output reg cardDiscardExpired_q,
    output reg hostDiscardExpired_q,
    input wire cardSpkr,
    input wire cardIois16,
    input wire cardInpack,
    output reg dmaRequest_q,
    input wire [31:0] ioAddr,
    input wire ioValid,
    output reg ddmaHit_q,
    output reg [3:0] ddmaRegIndex_q,
    output reg xferWide_q
);
    reg [7:0] diagCtl_q;
    reg [1:0] requestPinSelect_q;
    reg [11:0] ddmaIoBase_q;
    reg [1:0] transferWidth_q;
    reg ddmaDecodeEnable_q;
    reg [6:0] retryCount_q;
    reg [31:0] readValue;
    reg routeOk;
    reg pinLevel;
    wire [6:0] retryLast;
    wire cardExpire;
    wire hostExpire;

    ////////////////////////////////////////////////////////////////////
    // register writes
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            diagCtl_q <= `SDC_DIAG_RESET;
            requestPinSelect_q <= `SDC_DREQ_RESET;
            ddmaIoBase_q <= `SDC_BASE_RESET;
            transferWidth_q <= `SDC_WIDTH_RESET;
            ddmaDecodeEnable_q <= 1'b0; // R17
        end
        else if (clkEn && regWr)
        begin
            // bit 6 is plain storage, every bit of the byte is writable
            if (regAddr == `SDC_ADDR_DIAG)
            begin
                diagCtl_q <= regWdata[`SDC_DIAG_MSB:`SDC_FIELD_LSB]; // R10
            end
            else if (regAddr == `SDC_ADDR_DREQ)
            begin
                requestPinSelect_q <= regWdata[`SDC_DREQ_MSB:`SDC_FIELD_LSB]; // R11
            end
            else if (regAddr == `SDC_ADDR_WIN)
            begin
                ddmaIoBase_q <= regWdata[`SDC_WIN_BASE_MSB:`SDC_WIN_BASE_LSB]; // R15
                transferWidth_q <= regWdata[`SDC_WIN_WIDTH_MSB:`SDC_WIN_WIDTH_LSB]; // R16
                ddmaDecodeEnable_q <= regWdata[`SDC_WIN_EN_BIT]; // R17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read decode
    always @*
    begin
        readValue = `SDC_ZERO32;
        if (regAddr == `SDC_ADDR_IDENT)
        begin
            if (diagCtl_q[`SDC_DIAG_ID_MASK])
            begin
                readValue = `SDC_ONES32; // R01
            end
            else
            begin
                readValue = {DEVICE_ID, VENDOR_ID}; // R01
            end
        end
        else if (regAddr == `SDC_ADDR_DIAG)
        begin
            readValue[`SDC_DIAG_MSB:`SDC_FIELD_LSB] = diagCtl_q;
        end
        else if (regAddr == `SDC_ADDR_DREQ)
        begin
            readValue[`SDC_DREQ_MSB:`SDC_FIELD_LSB] = requestPinSelect_q; // R12
        end
        else if (regAddr == `SDC_ADDR_WIN)
        begin
            // bit 3 and bits 31:16 stay zero
            readValue[`SDC_WIN_BASE_MSB:`SDC_WIN_BASE_LSB] = ddmaIoBase_q; // R18
            readValue[`SDC_WIN_WIDTH_MSB:`SDC_WIN_WIDTH_LSB] = transferWidth_q;
            readValue[`SDC_WIN_EN_BIT] = ddmaDecodeEnable_q;
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            regRdata_q <= `SDC_ZERO32;
        end
        else if (clkEn)
        begin
            regRdata_q <= regRd ? readValue : `SDC_ZERO32;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // card-change routing and request pin choice
    always @*
    begin
        if (diagCtl_q[`SDC_DIAG_ROUTE_SEL])
        begin
            routeOk = (compat805Irq == 4'h0); // R03
        end
        else
        begin
            routeOk = compat803Bit4; // R02
        end
    end

    // unselected pins are ignored, so the card may toggle them freely
    always @*
    begin
        if (requestPinSelect_q == `SDC_DREQ_SPKR)
        begin
            pinLevel = cardSpkr; // R11
        end
        else if (requestPinSelect_q == `SDC_DREQ_IOIS16)
        begin
            pinLevel = cardIois16; // R11
        end
        else if (requestPinSelect_q == `SDC_DREQ_INPACK)
        begin
            pinLevel = cardInpack; // R11
        end
        else
        begin
            pinLevel = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // retry latency: wait cycles before a retry is forced
    assign retryLast = diagCtl_q[`SDC_DIAG_RETRY_LATENCY_LONG] ?
        `SDC_RETRY_LONG - 7'h01 : `SDC_RETRY_SHORT - 7'h01; // R05

    sdc_discard_timer #(
        .SHORT_LIMIT(DISCARD_SHORT),
        .LONG_LIMIT(DISCARD_LONG)
    ) cardTimer (
        .clk(clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .run(cardDiscardRun && !diagCtl_q[`SDC_DIAG_DELAYED_TXN_OFF]),
        .selShort(diagCtl_q[`SDC_DIAG_CB_DISCARD]), // R06
        .expired_q(cardExpire)
    );

    sdc_discard_timer #(
        .SHORT_LIMIT(DISCARD_SHORT),
        .LONG_LIMIT(DISCARD_LONG)
    ) hostTimer (
        .clk(clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .run(hostDiscardRun && !diagCtl_q[`SDC_DIAG_DELAYED_TXN_OFF]),
        .selShort(diagCtl_q[`SDC_DIAG_HOST_DISCARD]), // R07
        .expired_q(hostExpire)
    );

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            changeIrqHost_q <= 1'b0;
            changeIrqAsync_q <= 1'b0;
            delayedTxnOff_q <= 1'b0;
            cardDiscardExpired_q <= 1'b0;
            hostDiscardExpired_q <= 1'b0;
            dmaRequest_q <= 1'b0;
        end
        else if (clkEn)
        begin
            changeIrqHost_q <= changePending && routeOk; // R02 R03
            changeIrqAsync_q <= changePending && routeOk
                && diagCtl_q[`SDC_DIAG_CHANGE_IRQ_ENABLE_A_EN]; // R08
            delayedTxnOff_q <= diagCtl_q[`SDC_DIAG_DELAYED_TXN_OFF]; // R04
            cardDiscardExpired_q <= cardExpire; // R06
            hostDiscardExpired_q <= hostExpire; // R07
            dmaRequest_q <= pinLevel; // R11
        end
    end

    ////////////////////////////////////////////////////////////////////
    // retry latency counter, one pulse per elapsed limit
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            retryCount_q <= 7'h00;
            retryTimeout_q <= 1'b0;
        end
        else if (clkEn)
        begin
            // with delayed transactions off there is no retry to time
            retryTimeout_q <= 1'b0;
            if (!retryWait || diagCtl_q[`SDC_DIAG_DELAYED_TXN_OFF])
            begin
                retryCount_q <= 7'h00; // R04
            end
            else if (retryCount_q >= retryLast)
            begin
                retryCount_q <= 7'h00;
                retryTimeout_q <= 1'b1; // R05
            end
            else
            begin
                retryCount_q <= retryCount_q + 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // DMA window decode, one cycle behind the io address
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ddmaHit_q <= 1'b0;
            ddmaRegIndex_q <= 4'h0;
            xferWide_q <= 1'b0;
        end
        else if (clkEn)
        begin
            // upper half must be zero: window lives below 64 Kbytes
            ddmaHit_q <= ioValid && ddmaDecodeEnable_q
                && (ioAddr[`SDC_IO_UPPER_MSB:`SDC_IO_UPPER_LSB] == `SDC_IO_UPPER_ZERO)
                && (ioAddr[`SDC_WIN_BASE_MSB:`SDC_WIN_BASE_LSB] == ddmaIoBase_q); // R13 R17
            ddmaRegIndex_q <= ioAddr[`SDC_IO_INDEX_MSB:`SDC_FIELD_LSB]; // R13
            // reserved width codes fall back to 8 bits; never wider than 16
            xferWide_q <= (transferWidth_q == `SDC_WIDTH_16); // R14 R16
        end
    end
endmodule // sdc_config

/* logic/sdc_defines.vh */
/*
 * Constants of the socket DMA and diagnostic configuration bank:
 * register offsets, field positions, reset values, codes and counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH

// register offsets, byte addresses on the register port
`define SDC_ADDR_IDENT 8'h00
`define SDC_ADDR_DIAG 8'h93
`define SDC_ADDR_DREQ 8'h94
`define SDC_ADDR_WIN 8'h98

// diagnostic controls fields
`define SDC_DIAG_RESET 8'h61
`define SDC_DIAG_ID_MASK 7
`define SDC_DIAG_SPARE 6
`define SDC_DIAG_ROUTE_SEL 5
`define SDC_DIAG_DELAYED_TXN_OFF 4
`define SDC_DIAG_RETRY_LATENCY_LONG 3
`define SDC_DIAG_CB_DISCARD 2
`define SDC_DIAG_HOST_DISCARD 1
`define SDC_DIAG_CHANGE_IRQ_ENABLE_A_EN 0

// request pin select codes
`define SDC_DREQ_RESET 2'h0
`define SDC_DREQ_NONE 2'h0
`define SDC_DREQ_SPKR 2'h1
`define SDC_DREQ_IOIS16 2'h2
`define SDC_DREQ_INPACK 2'h3

// window control fields
`define SDC_WIN_EN_BIT 0
`define SDC_WIN_WIDTH_LSB 1
`define SDC_WIN_WIDTH_MSB 2
`define SDC_WIN_BASE_LSB 4
`define SDC_WIN_BASE_MSB 15
`define SDC_WIDTH_RESET 2'h0
`define SDC_WIDTH_16 2'h1
`define SDC_BASE_RESET 12'h000

// field spans of the diagnostic byte, request select and io address
`define SDC_DIAG_MSB 7
`define SDC_FIELD_LSB 0
`define SDC_DREQ_MSB 1
`define SDC_IO_UPPER_MSB 31
`define SDC_IO_UPPER_LSB 16
`define SDC_IO_INDEX_MSB 3
`define SDC_IO_UPPER_ZERO 16'h0000

// retry latency limits and discard timer lengths, in clocks
`define SDC_RETRY_SHORT 7'h10
`define SDC_RETRY_LONG 7'h40
`define SDC_DISCARD_SHORT 1024
`define SDC_DISCARD_LONG 32768

`define SDC_ZERO32 32'h00000000
`define SDC_ONES32 32'hFFFFFFFF

`endif

/* testbench/sdc_card_model.sv */
/*
 * Model of the 16-bit card in the socket: drives its three pins.
 * Assumes the bench chooses the pin levels on drive.
 */
`timescale 1ns/1ns
module sdc_card_model (
    input wire clk,
    input wire [2:0] drive,
    output reg cardSpkr = 1'b0,
    output reg cardIois16 = 1'b0,
    output reg cardInpack = 1'b0
);
    // card pins change only after an edge, like a real synchronous card
    always @(posedge clk)
    begin
        {cardInpack, cardIois16, cardSpkr} <= drive;
    end
endmodule // sdc_card_model

/* testbench/sdc_config_monitor.sv */
/*
 * Checker on the ports of sdc_config.
 * Assumes clkEn is lowered only while the watched inputs stand still.
 */
`timescale 1ns/1ns
module sdc_config_monitor (
    input wire clk,
    input wire nrst,
    input wire [7:0] regAddr,
    input wire regWr,
    input wire regRd,
    input wire [31:0] regRdata_q,
    input wire changePending,
    input wire changeIrqHost_q,
    input wire changeIrqAsync_q,
    input wire delayedTxnOff_q,
    input wire retryTimeout_q,
    input wire cardDiscardExpired_q,
    input wire [31:0] ioAddr,
    input wire ioValid,
    input wire ddmaHit_q,
    input wire [3:0] ddmaRegIndex_q,
    input wire xferWide_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    a_dreq_zero: assert property (regRd && regAddr == 8'h94 |=> regRdata_q[31:2] == 30'h0)
        else $error("request select upper bits not zero");
    a_win_fixed_zero: assert property (
        regRd && regAddr == 8'h98 |=> regRdata_q[31:16] == 16'h0 && !regRdata_q[3])
        else $error("window fixed bits not zero");
    a_hit_low_io: assert property (
        ddmaHit_q |-> $past(ioValid) && $past(ioAddr[31:16]) == 16'h0)
        else $error("window hit outside low io space");
    a_hit_index: assert property (ddmaHit_q |-> ddmaRegIndex_q == $past(ioAddr[3:0]))
        else $error("window index wrong");
    a_change_irq_enable_a_gated: assert property (changeIrqAsync_q |-> changeIrqHost_q)
        else $error("change_irq_enable_a irq without routed irq");
    a_irq_cause: assert property (changeIrqHost_q |-> $past(changePending))
        else $error("routed irq without pending change");
    a_retry_gap: assert property (retryTimeout_q |=> (!retryTimeout_q) [*8])
        else $error("retry timeouts too close");
    a_txn_off_write: assert property (
        $changed(delayedTxnOff_q) |-> $past(regWr, 2) && $past(regAddr, 2) == 8'h93)
        else $error("retry disable changed without write");
    a_width_write: assert property (
        $changed(xferWide_q) |-> $past(regWr, 2) && $past(regAddr, 2) == 8'h98)
        else $error("width changed without write");
    a_discard_pulse: assert property (cardDiscardExpired_q |=> !cardDiscardExpired_q)
        else $error("discard expiry longer than a pulse");
    cover property (regRd && regAddr == 8'h00);
    cover property (ddmaHit_q);
    cover property (retryTimeout_q);
endmodule // sdc_config_monitor

bind sdc_config sdc_config_monitor mon (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regRdata_q(regRdata_q), .changePending(changePending),
    .changeIrqHost_q(changeIrqHost_q), .changeIrqAsync_q(changeIrqAsync_q),
    .delayedTxnOff_q(delayedTxnOff_q), .retryTimeout_q(retryTimeout_q),
    .cardDiscardExpired_q(cardDiscardExpired_q), .ioAddr(ioAddr), .ioValid(ioValid),
    .ddmaHit_q(ddmaHit_q), .ddmaRegIndex_q(ddmaRegIndex_q), .xferWide_q(xferWide_q)
);

/* testbench/tb.sv */
/*
 * Self-checking bench for sdc_config with a card model.
 * Assumes small discard limits of 4 and 16 clocks.
 */
`timescale 1ns/1ns
module tb;
    reg clk = 0, nrst = 0, clkEn = 1, regWr = 0, regRd = 0, ioValid = 0, hit;
    reg changePending = 0, compat803Bit4 = 0, retryWait = 0;
    reg cardDiscardRun = 0, hostDiscardRun = 0;
    reg [7:0] regAddr = 8'h00;
    reg [31:0] regWdata = 32'h0, ioAddr = 32'h0;
    reg [3:0] compat805Irq = 4'h0;
    reg [2:0] drive = 3'h0;
    wire [31:0] regRdata_q;
    wire [3:0] ddmaRegIndex_q;
    wire cardSpkr, cardIois16, cardInpack, changeIrqHost_q, changeIrqAsync_q, delayedTxnOff_q;
    wire retryTimeout_q, cardDiscardExpired_q, hostDiscardExpired_q, dmaRequest_q, ddmaHit_q;
    wire xferWide_q;
    integer errors = 0, checkCount = 0, cyc = 0, n, i;
    sdc_config #(.DISCARD_SHORT(4), .DISCARD_LONG(16)) DUT (
        .clk(clk), .nrst(nrst), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
        .changePending(changePending), .compat803Bit4(compat803Bit4),
        .compat805Irq(compat805Irq), .changeIrqHost_q(changeIrqHost_q),
        .changeIrqAsync_q(changeIrqAsync_q), .delayedTxnOff_q(delayedTxnOff_q),
        .retryWait(retryWait), .retryTimeout_q(retryTimeout_q),
        .cardDiscardRun(cardDiscardRun), .hostDiscardRun(hostDiscardRun),
        .cardDiscardExpired_q(cardDiscardExpired_q),
        .hostDiscardExpired_q(hostDiscardExpired_q),
        .cardSpkr(cardSpkr), .cardIois16(cardIois16), .cardInpack(cardInpack),
        .dmaRequest_q(dmaRequest_q), .ioAddr(ioAddr), .ioValid(ioValid),
        .ddmaHit_q(ddmaHit_q), .ddmaRegIndex_q(ddmaRegIndex_q), .xferWide_q(xferWide_q)
    );
    sdc_card_model card (
        .clk(clk), .drive(drive), .cardSpkr(cardSpkr), .cardIois16(cardIois16),
        .cardInpack(cardInpack)
    );
    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] g, input [31:0] e);
    begin
        checkCount = checkCount + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    task tick(input integer k);
    begin
        repeat (k) @(posedge clk);
        #1;
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk);
        regWr <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 0;
    end
    endtask
    task rd(input [7:0] a, input [31:0] e);
    begin
        @(posedge clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 0;
        #1;
        chk(regRdata_q, e);
    end
    endtask
    task io(input [31:0] a, input h);
    begin
        @(posedge clk);
        ioValid <= 1;
        ioAddr <= a;
        tick(1);
        chk(ddmaHit_q, h);
        chk(ddmaRegIndex_q, a[3:0]);
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
    begin
        rd(8'h93, 32'h61);
        rd(8'h94, 32'h0);
        rd(8'h98, 32'h0);
        rd(8'h40, 32'h0);
        rd(8'h00, 32'h56781234);
        wr(8'h93, 32'hE1);
        rd(8'h93, 32'hE1);
        rd(8'h00, 32'hFFFFFFFF);
        wr(8'h93, 32'h61);
        $display("registers test ended");
    end
    endtask
    // strobes while clkEn is low must leave the diagnostic register untouched
    task t_freeze;
    begin
        @(posedge clk);
        clkEn <= 0;
        wr(8'h93, 32'hFF);
        rd(8'h93, 32'h0);
        @(posedge clk);
        clkEn <= 1;
        rd(8'h93, 32'h61);
        $display("clock enable test ended");
    end
    endtask
    // every code, with only the unselected pins high the request must stay low
    task t_dreq;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h94, 32'hFFFFFFFC | i);
            rd(8'h94, i);
            @(posedge clk);
            drive <= 3'h7;
            tick(2);
            chk(dmaRequest_q, i != 0);
            @(posedge clk);
            drive <= 3'h7 ^ (i == 0 ? 3'h0 : 3'h1 << (i - 1));
            tick(2);
            chk(dmaRequest_q, 0);
        end
        $display("request pin test ended");
    end
    endtask
    task t_window;
    begin
        wr(8'h98, 32'hFFFFFFFF);
        rd(8'h98, 32'h0000FFF7);
        chk(xferWide_q, 0);
        wr(8'h98, 32'h00001231);
        io(32'h00001235, 1);
        io(32'h10001235, 0);
        io(32'h00001245, 0);
        chk(xferWide_q, 0);
        wr(8'h98, 32'h00001233);
        tick(1);
        chk(xferWide_q, 1);
        wr(8'h98, 32'h00001232);
        io(32'h0000123F, 0);
        $display("window test ended");
    end
    endtask
    task t_route;
    begin
        @(posedge clk);
        changePending <= 1;
        compat803Bit4 <= 1;
        tick(1);
        chk({changeIrqHost_q, changeIrqAsync_q}, 2'h3);
        @(posedge clk);
        compat805Irq <= 4'h8;
        tick(1);
        chk(changeIrqHost_q, 0);
        wr(8'h93, 32'h41);
        tick(1);
        chk(changeIrqHost_q, 1);
        @(posedge clk);
        compat803Bit4 <= 0;
        tick(1);
        chk(changeIrqHost_q, 0);
        wr(8'h93, 32'h60);
        @(posedge clk);
        compat805Irq <= 4'h0;
        tick(1);
        chk({changeIrqHost_q, changeIrqAsync_q}, 2'h2);
        $display("routing test ended");
    end
    endtask
    // src 0 retry, 1 card-side discard, 2 host-side discard; 100 means none seen
    task t_count(input [7:0] d, input [1:0] src, input integer e);
    begin
        wr(8'h93, d);
        @(posedge clk);
        retryWait <= src == 0;
        cardDiscardRun <= src == 1;
        hostDiscardRun <= src == 2;
        n = 0;
        hit = 0;
        while (!hit && n < 100)
        begin
            tick(1);
            n = n + 1;
            hit = src == 0 ? retryTimeout_q
                : src == 1 ? cardDiscardExpired_q : hostDiscardExpired_q;
        end
        chk(n, e);
        @(posedge clk);
        {retryWait, cardDiscardRun, hostDiscardRun} <= 3'h0;
    end
    endtask
    task t_retry;
    begin
        t_count(8'h61, 0, 16);
        t_count(8'h69, 0, 64);
        $display("retry latency test ended");
    end
    endtask
    task t_discard;
    begin
        t_count(8'h65, 1, 5);
        t_count(8'h61, 1, 17);
        t_count(8'h63, 2, 5);
        t_count(8'h61, 2, 17);
        $display("discard timer test ended");
    end
    endtask
    // retry disable also holds the retry counter and the card-side discard timer idle
    task t_retry_off;
    begin
        t_count(8'h71, 0, 100);
        t_count(8'h75, 1, 100);
        chk(delayedTxnOff_q, 1);
        $display("retry disable test ended");
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    // ceiling well above the roughly 460 clocks the sequence needs
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 6000)
        begin
            errors = errors + 1;
            stop_test;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1;
        t_regs;
        t_freeze;
        t_dreq;
        t_window;
        t_route;
        t_retry;
        t_discard;
        t_retry_off;
        stop_test;
    end
endmodule // tb
